// ---- pkg/dilpc_pkg.sv ----
// constants, types and decode functions of the interrupt and low-power controller
// assumes one core clock at the instruction rate; the input clock runs at half that rate
package dilpc_pkg;

  localparam int NUM_SRC = 11;
  localparam int IDX_W   = 4;
  localparam int MASK_W  = 10;
  localparam int CTRL_W  = 4;
  localparam int STAT_W  = 8;
  localparam int PTR_W   = 4;
  localparam int CNT_W   = 14;
  localparam int PIN_W   = 7;
  localparam int FLAG_W  = 6;

  // source index, also priority order (0 is highest)
  localparam logic [IDX_W-1:0] IDX_PWRDN   = 4'h0;
  localparam logic [IDX_W-1:0] IDX_EXT_SEL = 4'h1;
  localparam logic [IDX_W-1:0] IDX_LVL_B   = 4'h2;
  localparam logic [IDX_W-1:0] IDX_LVL_A   = 4'h3;
  localparam logic [IDX_W-1:0] IDX_SP0_TX  = 4'h4;
  localparam logic [IDX_W-1:0] IDX_SP0_RX  = 4'h5;
  localparam logic [IDX_W-1:0] IDX_EDGE    = 4'h6;
  localparam logic [IDX_W-1:0] IDX_BYTE_DMA = 4'h7;
  localparam logic [IDX_W-1:0] IDX_SP1_TX  = 4'h8;
  localparam logic [IDX_W-1:0] IDX_SP1_RX  = 4'h9;
  localparam logic [IDX_W-1:0] IDX_TIMER   = 4'ha;
  localparam logic [IDX_W-1:0] IDX_NONE    = 4'hf;
  localparam logic [NUM_SRC-1:0] ONE_SRC   = 11'h001;

  // vector addresses
  localparam logic [15:0] VEC_RESET    = 16'h0000;
  localparam logic [15:0] VEC_PWRDN    = 16'h002c;
  localparam logic [15:0] VEC_EXT_SEL  = 16'h0004;
  localparam logic [15:0] VEC_LVL_B    = 16'h0008;
  localparam logic [15:0] VEC_LVL_A    = 16'h000c;
  localparam logic [15:0] VEC_SP0_TX   = 16'h0010;
  localparam logic [15:0] VEC_SP0_RX   = 16'h0014;
  localparam logic [15:0] VEC_EDGE     = 16'h0018;
  localparam logic [15:0] VEC_BYTE_DMA = 16'h001c;
  localparam logic [15:0] VEC_SP1_TX   = 16'h0020;
  localparam logic [15:0] VEC_SP1_RX   = 16'h0024;
  localparam logic [15:0] VEC_TIMER    = 16'h0028;

  // int_ctrl_reg bit positions
  localparam int CTRL_EXT_EDGE  = 0;
  localparam int CTRL_ALTA_EDGE = 1;
  localparam int CTRL_ALTB_EDGE = 2;
  localparam int CTRL_NEST      = 3;

  // pin positions in the synchronised group
  localparam int PIN_EXT = 0;
  localparam int PIN_LVL_B = 1;
  localparam int PIN_LVL_A = 2;
  localparam int PIN_EDGE = 3;
  localparam int PIN_ALT_A = 4;
  localparam int PIN_ALT_B = 5;
  localparam int PIN_PWD = 6;
  localparam logic [PIN_W-1:0] PIN_IDLE = 7'h7f;

  // power-down recovery, in input clock cycles, then core cycles
  localparam int CORE_PER_INPUT_CLOCK  = 2;
  localparam int RECOVER_INPUT_CLOCK   = 400;
  localparam int OSC_START_INPUT_CLOCK = 4096;
  localparam int RECOVER_CYC     = RECOVER_INPUT_CLOCK * CORE_PER_INPUT_CLOCK;
  localparam int OSC_START_CYC   = OSC_START_INPUT_CLOCK * CORE_PER_INPUT_CLOCK;

  localparam logic [7:0] IDLE_DIV_BASE = 8'h10;
  localparam logic [PTR_W-1:0] STACK_DEPTH = 4'hc;
  localparam logic [STAT_W-1:0] STAT_RST = 8'h00;

  typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_PWRDN, ST_RECOVER} dilpc_state_t;

  // lowest set index, IDX_NONE when empty
  function automatic logic [IDX_W-1:0] dilpc_first(input logic [NUM_SRC-1:0] v);
    logic [IDX_W-1:0] r;
    r = IDX_NONE;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) r = IDX_W'(i);
    end
    return r;
  endfunction

  function automatic logic [15:0] dilpc_vector(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_PWRDN:    return VEC_PWRDN;
      IDX_EXT_SEL:  return VEC_EXT_SEL;
      IDX_LVL_B:    return VEC_LVL_B;
      IDX_LVL_A:    return VEC_LVL_A;
      IDX_SP0_TX:   return VEC_SP0_TX;
      IDX_SP0_RX:   return VEC_SP0_RX;
      IDX_EDGE:     return VEC_EDGE;
      IDX_BYTE_DMA: return VEC_BYTE_DMA;
      IDX_SP1_TX:   return VEC_SP1_TX;
      IDX_SP1_RX:   return VEC_SP1_RX;
      IDX_TIMER:    return VEC_TIMER;
      default:      return VEC_RESET;
    endcase
  endfunction

endpackage

// ---- pkg/dilpc_sel_if.sv ----
// selection path between the controller and its priority encoder
// assumes the controller drives clock, reset and the request vectors
`timescale 1ns/10ps
`default_nettype none
interface dilpc_sel_if;
  import dilpc_pkg::*;
  logic                 clk;
  logic                 rst_n;
  logic [NUM_SRC-1:0]   req;
  logic [NUM_SRC-1:0]   in_service;
  logic                 nest_en;
  logic                 valid;
  logic [IDX_W-1:0]     idx;
  modport enc  (input clk, rst_n, req, in_service, nest_en, output valid, idx);
  modport user (output clk, rst_n, req, in_service, nest_en, input valid, idx);
endinterface
`default_nettype wire

// ---- rtl/dilpc_sync.sv ----
// two-flop synchroniser for a group of asynchronous pins
// assumes pins idle at RST_VAL
`timescale 1ns/10ps
`default_nettype none
module dilpc_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // dilpc_sync
`default_nettype wire

// ---- rtl/dilpc_prio.sv ----
// priority encoder with nesting check against the handlers in service
// assumes requests already masked and gated by the controller
`timescale 1ns/10ps
`default_nettype none
module dilpc_prio
  import dilpc_pkg::*;
(
  dilpc_sel_if.enc sel
);
  logic [IDX_W-1:0] cand;
  logic [IDX_W-1:0] top_is;

  always_comb begin
    cand      = dilpc_first(sel.req);
    top_is    = dilpc_first(sel.in_service);
    sel.idx   = cand;
    // nested: only strictly higher priority preempts; else wait for none in service
    sel.valid = (sel.req != '0) &&
                ((sel.in_service == '0) || (sel.nest_en && (cand < top_is)));
  end

  a_prio_highest: assert property (@(posedge sel.clk) disable iff (!sel.rst_n)
    sel.valid |-> sel.req[sel.idx] && ((sel.req & ((ONE_SRC << sel.idx) - ONE_SRC)) == '0))
    else $error("selected request is not the highest pending");
  a_nest_only: assert property (@(posedge sel.clk) disable iff (!sel.rst_n)
    (sel.valid && (sel.in_service != '0)) |-> sel.nest_en && (sel.idx < dilpc_first(sel.in_service)))
    else $error("preemption without nesting or by lower priority");
endmodule // dilpc_prio
`default_nettype wire

// ---- rtl/dilpc_ctrl.sv ----
// interrupt controller and low-power sequencer of the dsp core
// assumes pins are asynchronous and active low; sequencer strobes are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module dilpc_ctrl
  import dilpc_pkg::*;
#(
  parameter int unsigned OSC_WAIT_CYC = OSC_START_CYC
) (
  // clock and reset
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RSTN,
  // interrupt pins, active low, asynchronous
  input  wire logic              I_EXT_IRQ_SEL_N,
  input  wire logic              I_LEVEL_IRQ_B_N,
  input  wire logic              I_LEVEL_IRQ_A_N,
  input  wire logic              I_EDGE_IRQ_N,
  input  wire logic              I_ALT_IRQ_A_N,
  input  wire logic              I_ALT_IRQ_B_N,
  input  wire logic              I_POWERDOWN_PIN_N,
  // programmable flag drive of the shared pins
  input  wire logic [FLAG_W-1:0] I_FLAG_OE,
  input  wire logic [FLAG_W-1:0] I_FLAG_VAL,
  // on-chip peripheral request pulses
  input  wire logic              I_SP0_TX,
  input  wire logic              I_SP0_RX,
  input  wire logic              I_BYTE_DMA,
  input  wire logic              I_SP1_TX,
  input  wire logic              I_SP1_RX,
  input  wire logic              I_TIMER,
  input  wire logic              I_SP1_RECONFIG,
  // control words
  input  wire logic [MASK_W-1:0] I_INT_MASK,
  input  wire logic              I_MASK_WR,
  input  wire logic [CTRL_W-1:0] I_INT_CTRL,
  input  wire logic              I_FORCE_CLR_WR,
  input  wire logic [NUM_SRC-1:0] I_FORCE_BITS,
  input  wire logic [NUM_SRC-1:0] I_CLEAR_BITS,
  input  wire logic              I_CONTEXT_KEEP,
  input  wire logic              I_OSC_OFF,
  // sequencer strobes
  input  wire logic              I_INT_ACK,
  input  wire logic              I_RTI,
  input  wire logic              I_NEST_PUSH,
  input  wire logic              I_NEST_POP,
  input  wire logic [STAT_W-1:0] I_STATUS,
  input  wire logic              I_GLOBAL_INT_ENABLE_OP,
  input  wire logic              I_GLOBAL_INT_DISABLE_OP,
  input  wire logic              I_IDLE,
  input  wire logic              I_IDLE_DIV_EN,
  input  wire logic [1:0]        I_IDLE_DIV,
  input  wire logic              I_PWRDN_ENTER,
  // answers to the sequencer
  output var  logic              O_INT_REQ,
  output var  logic [15:0]       O_INT_VECTOR,
  output var  logic [STAT_W-1:0] O_STATUS_OUT,
  output var  logic              O_STACK_FULL,
  output var  logic              O_GLOBAL_EN,
  output var  logic              O_STALL,
  output var  logic              O_SCALED_TICK,
  output var  logic              O_RESUME,
  output var  logic              O_CONTEXT_CLEAR,
  output var  logic              O_PWRDN_ACK
);
  logic               rst_meta;
  logic               rst_n;
  logic [PIN_W-1:0]   pin_raw;
  logic [PIN_W-1:0]   pin_sync;
  logic [PIN_W-1:0]   act;
  logic [PIN_W-1:0]   act_q;
  logic [PIN_W-1:0]   fall;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] lvl;
  logic [NUM_SRC-1:0] set;
  logic [NUM_SRC-1:0] clr;
  logic [NUM_SRC-1:0] masked;
  logic [NUM_SRC-1:0] mask_ext;
  logic [NUM_SRC-1:0] mask_ext_q;
  logic [NUM_SRC-1:0] in_service;
  logic [NUM_SRC-1:0] ack_hot;
  logic [IDX_W-1:0]   cur_idx;
  logic               cur_is_reset;
  logic               reset_pend;
  logic               mask_block;
  logic               global_en;
  logic               ack;
  logic               wake_any;
  logic               can_serve;
  dilpc_state_t       st;
  dilpc_state_t       next_st;
  logic [CNT_W-1:0]   cnt;
  logic [CNT_W-1:0]   wait_q;
  logic               div_on;
  logic [1:0]         div_code;
  logic [7:0]         div_cnt;
  logic [7:0]         div_n;
  logic               tick;
  logic [STAT_W-1:0]  stk [STACK_DEPTH];
  logic [PTR_W-1:0]   ptr;
  logic [PTR_W-1:0]   next_ptr;
  logic               push;
  logic               pop;
  logic [7:0]         idle_wait;

  dilpc_sel_if sel ();

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign pin_raw = {I_POWERDOWN_PIN_N, I_ALT_IRQ_B_N, I_ALT_IRQ_A_N, I_EDGE_IRQ_N,
                    I_LEVEL_IRQ_A_N, I_LEVEL_IRQ_B_N, I_EXT_IRQ_SEL_N};

  dilpc_sync #(.W(PIN_W), .RST_VAL(PIN_IDLE)) u_sync (
    .clk   (I_CORE_CLK),
    .rst_n (rst_n),
    .d     (pin_raw),
    .q     (pin_sync)
  );

  // a pin driven as flag output still requests, as if driven from outside
  always_comb begin
    act = ~pin_sync;
    for (int i = 0; i < FLAG_W; i++) begin
      if (I_FLAG_OE[i]) act[i] = ~I_FLAG_VAL[i];
    end
    fall = act & ~act_q;
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) act_q <= '0;
    else        act_q <= act;
  end

  // level and edge sources; alt pins replace serial port one when reconfigured
  always_comb begin
    lvl = '0;
    set = '0;
    lvl[IDX_EXT_SEL]  = act[PIN_EXT] & ~I_INT_CTRL[CTRL_EXT_EDGE];
    lvl[IDX_LVL_B]    = act[PIN_LVL_B];
    lvl[IDX_LVL_A]    = act[PIN_LVL_A];
    lvl[IDX_SP1_TX]   = I_SP1_RECONFIG & act[PIN_ALT_B] & ~I_INT_CTRL[CTRL_ALTB_EDGE];
    lvl[IDX_SP1_RX]   = I_SP1_RECONFIG & act[PIN_ALT_A] & ~I_INT_CTRL[CTRL_ALTA_EDGE];
    set[IDX_PWRDN]    = fall[PIN_PWD];
    set[IDX_EXT_SEL]  = fall[PIN_EXT] & I_INT_CTRL[CTRL_EXT_EDGE];
    set[IDX_SP0_TX]   = I_SP0_TX;
    set[IDX_SP0_RX]   = I_SP0_RX;
    set[IDX_EDGE]     = fall[PIN_EDGE];
    set[IDX_BYTE_DMA] = I_BYTE_DMA;
    set[IDX_SP1_TX]   = I_SP1_RECONFIG ? (fall[PIN_ALT_B] & I_INT_CTRL[CTRL_ALTB_EDGE])
                                       : I_SP1_TX;
    set[IDX_SP1_RX]   = I_SP1_RECONFIG ? (fall[PIN_ALT_A] & I_INT_CTRL[CTRL_ALTA_EDGE])
                                       : I_SP1_RX;
    set[IDX_TIMER]    = I_TIMER;
    if (I_FORCE_CLR_WR) set = set | I_FORCE_BITS;
  end

  assign ack     = I_INT_ACK & O_INT_REQ;
  assign ack_hot = (ack && !cur_is_reset) ? (ONE_SRC << cur_idx) : '0;

  always_comb begin
    clr = ack_hot;
    if (I_FORCE_CLR_WR) clr = clr | I_CLEAR_BITS;
  end

  // set wins over clear
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) pend <= '0;
    else        pend <= (pend & ~clr) | set;
  end

  assign mask_ext  = {I_INT_MASK, 1'b1};
  assign masked    = (pend | lvl) & mask_ext;
  assign wake_any  = (masked != '0) && global_en;
  assign can_serve = global_en && !mask_block && (st == ST_RUN) && !reset_pend;

  assign sel.clk        = I_CORE_CLK;
  assign sel.rst_n      = rst_n;
  assign sel.req        = can_serve ? masked : '0;
  assign sel.in_service = in_service;
  assign sel.nest_en    = I_INT_CTRL[CTRL_NEST];

  dilpc_prio u_prio (
    .sel (sel)
  );

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) mask_block <= 1'b0;
    else        mask_block <= I_MASK_WR;
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n)          global_en <= 1'b1;
    else if (I_GLOBAL_INT_ENABLE_OP) global_en <= 1'b1;
    else if (I_GLOBAL_INT_DISABLE_OP) global_en <= 1'b0;
  end

  // reset vector pending after reset and after a context-clearing wake
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) reset_pend <= 1'b1;
    else if (st == ST_RECOVER && next_st == ST_RUN && !I_CONTEXT_KEEP) reset_pend <= 1'b1;
    else if (ack && cur_is_reset) reset_pend <= 1'b0;
  end

  // request is withdrawn in the cycle after an ack to avoid a repeat
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_INT_REQ    <= 1'b0;
      O_INT_VECTOR <= VEC_RESET;
      cur_idx      <= IDX_NONE;
      cur_is_reset <= 1'b0;
      mask_ext_q   <= '0;
    end else begin
      O_INT_REQ    <= ((reset_pend && st == ST_RUN) || sel.valid) && !ack;
      O_INT_VECTOR <= reset_pend ? VEC_RESET : dilpc_vector(sel.idx);
      cur_idx      <= sel.idx;
      cur_is_reset <= reset_pend;
      mask_ext_q   <= mask_ext;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) in_service <= '0;
    else if (I_RTI) in_service <= (in_service & ~(ONE_SRC << dilpc_first(in_service))) | ack_hot;
    else in_service <= in_service | ack_hot;
  end

  // status stack, shared with loop and call nesting
  assign push = ack | I_NEST_PUSH;
  assign pop  = I_RTI | I_NEST_POP;
  always_comb begin
    next_ptr = ptr;
    if (push && ptr < STACK_DEPTH) next_ptr = ptr + 4'h1;
    else if (pop && !push && ptr != '0) next_ptr = ptr - 4'h1;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (push && ptr < STACK_DEPTH) stk[ptr] <= I_STATUS;
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ptr          <= '0;
      O_STATUS_OUT <= STAT_RST;
      O_STACK_FULL <= 1'b0;
    end else begin
      ptr          <= next_ptr;
      O_STACK_FULL <= (next_ptr == STACK_DEPTH);
      if (pop && !push && ptr != '0) O_STATUS_OUT <= stk[ptr - 4'h1];
    end
  end

  // divided idle tick, n = 16 << code
  assign div_n = IDLE_DIV_BASE << div_code;
  assign tick  = (div_cnt == div_n - 8'h01);

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) div_cnt <= '0;
    else if (st != ST_IDLE || !div_on || tick) div_cnt <= '0;
    else div_cnt <= div_cnt + 8'h01;
  end

  always_comb begin
    next_st = st;
    case (st)
      ST_RUN: begin
        if (I_PWRDN_ENTER) next_st = ST_PWRDN;
        else if (I_IDLE)   next_st = ST_IDLE;
      end
      ST_IDLE: begin
        if (wake_any && (!div_on || tick)) next_st = ST_RUN;
      end
      ST_PWRDN: begin
        if (fall[PIN_PWD]) next_st = ST_RECOVER;
      end
      ST_RECOVER: begin
        if (cnt == wait_q - 14'h0001) next_st = ST_RUN;
      end
      default: next_st = ST_RUN;
    endcase
  end

  // async reset also ends power-down
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) st <= ST_RUN;
    else        st <= next_st;
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_on   <= 1'b0;
      div_code <= 2'h0;
    end else if (st == ST_RUN && I_IDLE && !I_PWRDN_ENTER) begin
      div_on   <= I_IDLE_DIV_EN;
      div_code <= I_IDLE_DIV;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt    <= '0;
      wait_q <= CNT_W'(RECOVER_CYC);
    end else if (st == ST_PWRDN) begin
      cnt    <= '0;
      wait_q <= I_OSC_OFF ? CNT_W'(OSC_WAIT_CYC) : CNT_W'(RECOVER_CYC);
    end else if (st == ST_RECOVER) begin
      cnt    <= cnt + 14'h0001;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_STALL         <= 1'b0;
      O_PWRDN_ACK     <= 1'b0;
      O_RESUME        <= 1'b0;
      O_CONTEXT_CLEAR <= 1'b0;
      O_SCALED_TICK   <= 1'b0;
      O_GLOBAL_EN     <= 1'b1;
    end else begin
      O_STALL         <= (next_st != ST_RUN);
      O_PWRDN_ACK     <= (next_st == ST_PWRDN);
      O_RESUME        <= (st == ST_RECOVER) && (next_st == ST_RUN);
      O_CONTEXT_CLEAR <= (st == ST_RECOVER) && (next_st == ST_RUN) && !I_CONTEXT_KEEP;
      O_SCALED_TICK   <= (st == ST_RUN) || (st == ST_IDLE && (!div_on || tick));
      O_GLOBAL_EN     <= global_en;
    end
  end

  // cycles an unmasked request has waited in idle
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) idle_wait <= '0;
    else if (st == ST_IDLE && wake_any && next_st == ST_IDLE) idle_wait <= idle_wait + 8'h01;
    else idle_wait <= '0;
  end

  sequence s_pd_exit;
    (st == ST_RECOVER) ##1 (st == ST_RUN);
  endsequence

  a_reset_vector: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    (O_INT_REQ && cur_is_reset) |-> (O_INT_VECTOR == VEC_RESET))
    else $error("reset request without reset vector");
  a_mask_gate: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    (O_INT_REQ && !cur_is_reset) |-> mask_ext_q[cur_idx] && (O_INT_VECTOR == dilpc_vector(cur_idx)))
    else $error("masked source requested or wrong vector");
  a_mask_block: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    (I_MASK_WR && !reset_pend) |=> ##1 !O_INT_REQ)
    else $error("request in the cycle after a mask write");
  a_global_gate: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    (!global_en && !reset_pend) |=> !O_INT_REQ)
    else $error("request while globally disabled");
  a_enable_reset: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    $rose(rst_n) |-> global_en && O_GLOBAL_EN)
    else $error("global gate not enabled after reset");
  a_edge_clear: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    (ack && !cur_is_reset && cur_idx == IDX_EDGE && !set[IDX_EDGE]) |=> !pend[IDX_EDGE])
    else $error("edge pending not cleared on ack");
  a_pd_ack: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    O_PWRDN_ACK |-> (st == ST_PWRDN) && O_STALL)
    else $error("power-down ack outside power-down");
  a_pd_resume: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    s_pd_exit |-> O_RESUME && ($past(cnt) == wait_q - 14'h0001))
    else $error("resume without full recovery count");
  a_stack_depth: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    (ptr <= STACK_DEPTH) && (O_STACK_FULL == (ptr == STACK_DEPTH)))
    else $error("stack pointer beyond depth");
  a_idle_wake: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    (st == ST_IDLE) |-> (idle_wait < div_n))
    else $error("divided idle wake took more than n cycles");
endmodule // dilpc_ctrl
`default_nettype wire

// ---- testbench/dilpc_src_model.sv ----
// model of the external interrupt sources on the pins
// assumes the bench raises a bit to assert that pin
`timescale 1ns/10ps
`default_nettype none
module dilpc_src_model
  import dilpc_pkg::*;
(
  // requests from the bench
  input  wire logic [PIN_W-1:0] i_assert,
  // pins, pulled high when released
  output var  logic [PIN_W-1:0] o_pin_n
);
  always_comb o_pin_n = ~i_assert;
endmodule // dilpc_src_model
`default_nettype wire

// ---- testbench/tb_dilpc_ctrl.sv ----
// self-checking bench of the interrupt and low-power controller
// assumes inputs change at the falling edge only
`timescale 1ns/10ps
`default_nettype none
module tb_dilpc_ctrl;
  import dilpc_pkg::*;
  logic               clk = 1'b0;
  logic               rstn = 1'b0;
  logic [PIN_W-1:0]   src = '0;
  logic [PIN_W-1:0]   pin_n;
  logic [5:0]         per = '0;
  logic [MASK_W-1:0]  mask = '1;
  logic [CTRL_W-1:0]  ctrl = '0;
  logic [NUM_SRC-1:0] fb = '0;
  logic               ack = 0, rti = 0, ena = 0, dis = 0, pwe = 0, fcw = 0, lo = 0;
  logic               req, gen, pack, stl;
  logic               mwr = 0, idl = 0, rcf = 0;
  logic [15:0]        vec;
  int                 num_errors = 0;
  int                 n_checks = 0;
  always #5 clk = ~clk;
  dilpc_src_model src_m (.i_assert(src), .o_pin_n(pin_n));
  dilpc_ctrl #(.OSC_WAIT_CYC(16)) dut (
    .I_CORE_CLK(clk), .I_RSTN(rstn), .I_EXT_IRQ_SEL_N(pin_n[0]), .I_LEVEL_IRQ_B_N(pin_n[1]),
    .I_LEVEL_IRQ_A_N(pin_n[2]), .I_EDGE_IRQ_N(pin_n[3]), .I_ALT_IRQ_A_N(pin_n[4]),
    .I_ALT_IRQ_B_N(pin_n[5]), .I_POWERDOWN_PIN_N(pin_n[6]), .I_FLAG_OE({FLAG_W{lo}}),
    .I_FLAG_VAL({FLAG_W{lo}}), .I_SP0_TX(per[5]), .I_SP0_RX(per[4]), .I_BYTE_DMA(per[3]),
    .I_SP1_TX(per[2]), .I_SP1_RX(per[1]), .I_TIMER(per[0]), .I_SP1_RECONFIG(rcf),
    .I_INT_MASK(mask), .I_MASK_WR(mwr), .I_INT_CTRL(ctrl), .I_FORCE_CLR_WR(fcw),
    .I_FORCE_BITS(fb), .I_CLEAR_BITS({NUM_SRC{lo}}), .I_CONTEXT_KEEP(lo), .I_OSC_OFF(lo),
    .I_INT_ACK(ack), .I_RTI(rti), .I_NEST_PUSH(lo), .I_NEST_POP(lo), .I_STATUS({STAT_W{lo}}),
    .I_GLOBAL_INT_ENABLE_OP(ena), .I_GLOBAL_INT_DISABLE_OP(dis), .I_IDLE(idl), .I_IDLE_DIV_EN(lo), .I_IDLE_DIV({2{lo}}),
    .I_PWRDN_ENTER(pwe), .O_INT_REQ(req), .O_INT_VECTOR(vec), .O_STATUS_OUT(),
    .O_STACK_FULL(), .O_GLOBAL_EN(gen), .O_STALL(stl), .O_SCALED_TICK(), .O_RESUME(),
    .O_CONTEXT_CLEAR(), .O_PWRDN_ACK(pack));
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  // request must stand with this vector, then it is taken
  task automatic take(input logic [15:0] v);
    chk("req", {15'h0, req}, 16'h0001);
    chk("vector", vec, v);
    pulse(ack);
  endtask
  task automatic no_req();
    cyc(5);
    chk("req", {15'h0, req}, 16'h0000);
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    cyc(16);
    rstn = 1'b1;
    cyc(5);
  endtask
  initial begin
    cyc(3000);
    num_errors++;
    close_out();
  end
  initial begin
    do_reset();
    chk("global_en", {15'h0, gen}, 16'h0001);
    take(16'h0000);
    pulse(rti);
    per = 6'h21;
    cyc(1);
    per = '0;
    cyc(4);
    take(16'h0010);
    no_req();
    pulse(rti);
    cyc(4);
    take(16'h0028);
    pulse(rti);
    mask = 10'h1ff;
    per = 6'h01;
    cyc(1);
    per = '0;
    no_req();
    mask = '1;
    cyc(4);
    take(16'h0028);
    pulse(rti);
    ctrl = 4'h8;
    src[PIN_EDGE] = 1'b1;
    cyc(6);
    take(16'h0018);
    per = 6'h20;
    cyc(1);
    per = '0;
    cyc(4);
    take(16'h0010);
    pulse(rti);
    cyc(1);
    pulse(rti);
    no_req();
    src = '0;
    pulse(dis);
    fb = 11'h040;
    pulse(fcw);
    fb = '0;
    no_req();
    pulse(ena);
    cyc(4);
    take(16'h0018);
    pulse(rti);
    per = 6'h01;
    mwr = 1'b1;
    cyc(1);
    per = '0;
    mwr = 1'b0;
    cyc(1);
    chk("req", {15'h0, req}, 16'h0000);
    cyc(1);
    take(16'h0028);
    pulse(rti);
    pulse(idl);
    chk("stall", {15'h0, stl}, 16'h0001);
    per = 6'h01;
    cyc(1);
    per = '0;
    cyc(4);
    chk("stall", {15'h0, stl}, 16'h0000);
    take(16'h0028);
    pulse(rti);
    rcf = 1'b1;
    ctrl = 4'h2;
    src[PIN_ALT_A] = 1'b1;
    cyc(6);
    take(16'h0024);
    pulse(rti);
    no_req();
    src = '0;
    rcf = 1'b0;
    mask = '0;
    src[PIN_PWD] = 1'b1;
    cyc(6);
    take(16'h002c);
    pulse(pwe);
    cyc(1);
    chk("pwrdn_ack", {15'h0, pack}, 16'h0001);
    do_reset();
    chk("pwrdn_ack", {15'h0, pack}, 16'h0000);
    close_out();
  end
endmodule // tb_dilpc_ctrl
`default_nettype wire
